// ---- design/adcf_status.sv ----
/*
  adcf_status: result storage and status flags of a converter controller, with an Avalon-MM slave.
  assumes the conversion core runs on i_clock and gives a one-cycle end-of-conversion strobe.
*/
`timescale 1ns/1ps
module adcf_status (
  input  wire logic                        i_clock,
  input  wire logic                        i_rstn,
  input  wire logic [7:0]                  i_address,
  input  wire logic                        i_read,
  input  wire logic                        i_write,
  input  wire logic [31:0]                 i_writedata,
  input  wire logic [3:0]                  i_byteenable,
  output logic      [31:0]                 o_readdata,
  output logic                             o_waitrequest,
  input  wire logic                        i_eoc_pulse,
  input  wire logic [adcf_pkg::CH_W-1:0]   i_eoc_channel,
  input  wire logic [adcf_pkg::DATA_W-1:0] i_eoc_data,
  output logic                             o_start,
  output logic                             o_sleep
);

  adcf_pkg::adcf_bus_state_type     state_q;
  logic                             waitrequest_q;
  logic [31:0]                      readdata_q;
  logic                             start_q;
  logic                             sleep_q;
  logic                             mode_sleep_q;
  logic [adcf_pkg::NUM_CH-1:0]      ch_en_q;
  logic [adcf_pkg::DATA_W-1:0]      cdr_q [adcf_pkg::NUM_CH];
  logic [adcf_pkg::DATA_W-1:0]      last_data_q;
  logic [adcf_pkg::CH_W-1:0]        last_ch_q;
  logic [adcf_pkg::NUM_CH-1:0]      eoc_q;
  logic [adcf_pkg::NUM_CH-1:0]      channel_overrun_flag_q;
  logic                             data_ready_flag_q;
  logic                             global_overrun_flag_q;

  logic                             accept;
  logic                             rd_acc;
  logic                             wr_done;
  logic                             wr_lane0;
  logic                             rd_sr;
  logic                             rd_lcdr;
  logic                             in_cdr;
  logic [7:0]                       cdr_off;
  logic [adcf_pkg::CH_W-1:0]        cdr_idx;
  logic [adcf_pkg::NUM_CH-1:0]      rd_cdr;
  logic [adcf_pkg::NUM_CH-1:0]      dis_now;
  logic [adcf_pkg::NUM_CH-1:0]      ch_live;
  logic                             store;
  logic [adcf_pkg::NUM_CH-1:0]      eoc_set;
  logic [adcf_pkg::NUM_CH-1:0]      eoc_clr;
  logic [adcf_pkg::NUM_CH-1:0]      channel_overrun_flag_set;
  logic [adcf_pkg::NUM_CH-1:0]      eoc_keep;
  logic [31:0]                      rd_word;

  // request decode
  assign accept   = (i_read | i_write) & (state_q == adcf_pkg::BUS_IDLE);
  assign rd_acc   = i_read & accept;
  assign wr_done  = i_write & (state_q == adcf_pkg::BUS_DONE);
  assign wr_lane0 = wr_done & i_byteenable[0];
  assign rd_sr    = rd_acc & (i_address == adcf_pkg::ADDR_STATUS);
  assign rd_lcdr  = rd_acc & (i_address == adcf_pkg::ADDR_LAST);
  assign in_cdr   = (i_address >= adcf_pkg::ADDR_CDR_BASE) && (i_address <= adcf_pkg::ADDR_CDR_TOP)
                    && (i_address[1:0] == 2'h0);
  assign cdr_off  = i_address - adcf_pkg::ADDR_CDR_BASE;
  assign cdr_idx  = cdr_off[adcf_pkg::CH_W+1:2];

  // disable takes hold in the same cycle, so a late end on it is dropped
  assign dis_now = (wr_lane0 && i_address == adcf_pkg::ADDR_CH_DIS) ? i_writedata[7:0] : 8'h00;
  assign ch_live = ch_en_q & ~dis_now;
  assign store   = i_eoc_pulse & ch_live[i_eoc_channel];

  // bus handshake: one wait cycle, then waitrequest low for one cycle
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      state_q       <= adcf_pkg::BUS_IDLE;
      waitrequest_q <= 1'b1;
    end else begin
      unique case (state_q)
        adcf_pkg::BUS_IDLE: begin
          if (i_read | i_write) begin
            state_q       <= adcf_pkg::BUS_DONE;
            waitrequest_q <= 1'b0;
          end
        end
        adcf_pkg::BUS_DONE: begin
          state_q       <= adcf_pkg::BUS_IDLE;
          waitrequest_q <= 1'b1;
        end
      endcase
    end
  end

  // read word; unmapped offsets read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (in_cdr) begin
      rd_word[adcf_pkg::DATA_W-1:0] = cdr_q[cdr_idx];
    end else begin
      unique case (i_address)
        adcf_pkg::ADDR_MODE: begin
          rd_word[adcf_pkg::MODE_SLEEP_BIT] = mode_sleep_q;
        end
        adcf_pkg::ADDR_CH_STAT: begin
          rd_word[7:0] = ch_en_q;
        end
        adcf_pkg::ADDR_STATUS: begin
          rd_word[adcf_pkg::SR_EOC_LSB +: adcf_pkg::NUM_CH]  = eoc_q;
          rd_word[adcf_pkg::SR_CHANNEL_OVERRUN_FLAG_LSB +: adcf_pkg::NUM_CH] = channel_overrun_flag_q;
          rd_word[adcf_pkg::SR_DATA_READY_FLAG_BIT]  = data_ready_flag_q;
          rd_word[adcf_pkg::SR_GLOBAL_OVERRUN_FLAG_BIT] = global_overrun_flag_q;
          rd_word[adcf_pkg::SR_SLEEP_BIT] = sleep_q;
        end
        adcf_pkg::ADDR_LAST: begin
          rd_word[adcf_pkg::DATA_W-1:0] = last_data_q;
          rd_word[adcf_pkg::LAST_CH_LSB +: adcf_pkg::CH_W] = last_ch_q;
        end
        default: begin
          rd_word = 32'h0000_0000;
        end
      endcase
    end
  end

  // data captured at the same edge the read side effects happen
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      readdata_q <= 32'h0000_0000;
    end else if (rd_acc) begin
      readdata_q <= rd_word;
    end
  end

  // channel enable set and clear writes
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      ch_en_q <= adcf_pkg::RST_CH_EN;
    end else if (wr_lane0 && i_address == adcf_pkg::ADDR_CH_EN) begin
      ch_en_q <= ch_en_q | i_writedata[7:0];
    end else begin
      ch_en_q <= ch_en_q & ~dis_now;
    end
  end

  // start command pulse to the core
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      start_q <= 1'b0;
    end else begin
      start_q <= wr_lane0 && (i_address == adcf_pkg::ADDR_CTRL) && i_writedata[adcf_pkg::CTRL_START_BIT];
    end
  end

  // mode register
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      mode_sleep_q <= adcf_pkg::RST_SLEEP;
    end else if (wr_lane0 && i_address == adcf_pkg::ADDR_MODE) begin
      mode_sleep_q <= i_writedata[adcf_pkg::MODE_SLEEP_BIT];
    end
  end

  // start wakes the core; sleep rises again at the next end-of-conversion strobe
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      sleep_q <= 1'b0;
    end else if (!mode_sleep_q || start_q) begin
      sleep_q <= 1'b0;
    end else if (i_eoc_pulse) begin
      sleep_q <= 1'b1;
    end
  end

  // last result register
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      last_data_q <= adcf_pkg::RST_DATA;
      last_ch_q   <= 3'h0;
    end else if (store) begin
      last_data_q <= i_eoc_data;
      last_ch_q   <= i_eoc_channel;
    end
  end

  // per-channel results and flags
  genvar g;
  generate
    for (g = 0; g < adcf_pkg::NUM_CH; g++) begin : g_ch
      localparam int unsigned CH_NUM = g;
      assign rd_cdr[g]   = rd_acc & in_cdr & (cdr_idx == CH_NUM[adcf_pkg::CH_W-1:0]);
      assign eoc_set[g]  = store & (i_eoc_channel == CH_NUM[adcf_pkg::CH_W-1:0]);
      assign eoc_clr[g]  = rd_cdr[g] | (rd_lcdr & (last_ch_q == CH_NUM[adcf_pkg::CH_W-1:0]));
      assign channel_overrun_flag_set[g] = eoc_set[g] & eoc_q[g];
      assign eoc_keep[g] = eoc_q[g] & ~eoc_clr[g];

      always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
          cdr_q[g] <= adcf_pkg::RST_DATA;
        end else if (eoc_set[g]) begin
          cdr_q[g] <= i_eoc_data;
        end
      end

      adcf_flag u_eoc (
        .i_clock (i_clock),
        .i_rstn  (i_rstn),
        .i_set   (eoc_set[g]),
        .i_clear (eoc_clr[g]),
        .o_flag  (eoc_q[g])
      );

      adcf_flag u_channel_overrun_flag (
        .i_clock (i_clock),
        .i_rstn  (i_rstn),
        .i_set   (channel_overrun_flag_set[g]),
        .i_clear (rd_sr),
        .o_flag  (channel_overrun_flag_q[g])
      );
    end
  endgenerate

  adcf_flag u_data_ready_flag (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .i_set   (store),
    .i_clear (rd_lcdr),
    .o_flag  (data_ready_flag_q)
  );

  adcf_flag u_global_overrun_flag (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .i_set   (store & data_ready_flag_q),
    .i_clear (rd_sr),
    .o_flag  (global_overrun_flag_q)
  );

  assign o_readdata    = readdata_q;
  assign o_waitrequest = waitrequest_q;
  assign o_start       = start_q;
  assign o_sleep       = sleep_q;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  property p_data_ready_flag_keep;
    data_ready_flag_q && (|rd_cdr) && !rd_lcdr |=> data_ready_flag_q;
  endproperty
  a_data_ready_flag_keep: assert property (p_data_ready_flag_keep) else $error("data ready lost on channel read");

  property p_data_ready_flag_clear;
    rd_lcdr && !store |=> !data_ready_flag_q;
  endproperty
  a_data_ready_flag_clear: assert property (p_data_ready_flag_clear) else $error("data ready not cleared by last read");

  property p_data_ready_flag_set;
    store |=> data_ready_flag_q && (last_data_q == $past(i_eoc_data));
  endproperty
  a_data_ready_flag_set: assert property (p_data_ready_flag_set) else $error("data ready or last data missed a store");

  property p_data_ready_flag_nostore;
    !data_ready_flag_q && !store |=> !data_ready_flag_q;
  endproperty
  a_data_ready_flag_nostore: assert property (p_data_ready_flag_nostore) else $error("data ready rose without a store");

  property p_eoc_set;
    store |=> eoc_q[$past(i_eoc_channel)];
  endproperty
  a_eoc_set: assert property (p_eoc_set) else $error("end flag not set on store");

  property p_eoc_disabled;
    i_eoc_pulse && !ch_live[i_eoc_channel] && !eoc_q[i_eoc_channel] |=> !eoc_q[$past(i_eoc_channel)];
  endproperty
  a_eoc_disabled: assert property (p_eoc_disabled) else $error("end flag rose on disabled channel");

  property p_eoc_other;
    |eoc_keep |=> ((eoc_q & $past(eoc_keep)) == $past(eoc_keep));
  endproperty
  a_eoc_other: assert property (p_eoc_other) else $error("end flag of unread channel cleared");

  property p_channel_overrun_flag_set;
    store && eoc_q[i_eoc_channel] |=> channel_overrun_flag_q[$past(i_eoc_channel)];
  endproperty
  a_channel_overrun_flag_set: assert property (p_channel_overrun_flag_set) else $error("channel overrun not set");

  property p_channel_overrun_flag_clear;
    rd_sr && !(store && eoc_q[i_eoc_channel]) |=> channel_overrun_flag_q == 8'h00;
  endproperty
  a_channel_overrun_flag_clear: assert property (p_channel_overrun_flag_clear) else $error("channel overrun not cleared by status read");

  property p_global_overrun_flag_set;
    store && data_ready_flag_q |=> global_overrun_flag_q;
  endproperty
  a_global_overrun_flag_set: assert property (p_global_overrun_flag_set) else $error("global overrun not set");

  property p_global_overrun_flag_clear;
    rd_sr && !(store && data_ready_flag_q) |=> !global_overrun_flag_q;
  endproperty
  a_global_overrun_flag_clear: assert property (p_global_overrun_flag_clear) else $error("global overrun not cleared");

  property p_sleep_wait;
    !sleep_q && !i_eoc_pulse |=> !sleep_q;
  endproperty
  a_sleep_wait: assert property (p_sleep_wait) else $error("sleep entered without a conversion end");

  property p_sleep_enter;
    mode_sleep_q && !start_q && i_eoc_pulse |=> sleep_q;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered after conversion end");

  property p_bus_answer;
    (i_read || i_write) && waitrequest_q && state_q == adcf_pkg::BUS_IDLE |=> !waitrequest_q ##1 waitrequest_q;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one cycle after request");

  c_overrun: cover property (store && data_ready_flag_q && eoc_q[i_eoc_channel]);
  c_sr_with_end: cover property (rd_sr && store);
  c_disable_with_end: cover property ((|dis_now) && store);
  c_sleep: cover property (!sleep_q ##1 sleep_q);

endmodule : adcf_status

// ---- design/adcf_pkg.sv ----
/*
  adcf_pkg: constants shared by the conversion status-flag block.
  assumes a 32-bit Avalon-MM slave with byte addresses and one aligned word per register.
*/
package adcf_pkg;

  localparam int NUM_CH = 8;
  localparam int DATA_W = 10;
  localparam int CH_W   = 3;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_MODE     = 8'h04;
  localparam logic [7:0] ADDR_CH_EN    = 8'h10;
  localparam logic [7:0] ADDR_CH_DIS   = 8'h14;
  localparam logic [7:0] ADDR_CH_STAT  = 8'h18;
  localparam logic [7:0] ADDR_STATUS   = 8'h1C;
  localparam logic [7:0] ADDR_LAST     = 8'h20;
  localparam logic [7:0] ADDR_CDR_BASE = 8'h30;
  localparam logic [7:0] ADDR_CDR_TOP  = 8'h4C;

  // field positions
  localparam int CTRL_START_BIT = 0;
  localparam int MODE_SLEEP_BIT = 0;
  localparam int SR_EOC_LSB     = 0;
  localparam int SR_CHANNEL_OVERRUN_FLAG_LSB    = 8;
  localparam int SR_DATA_READY_FLAG_BIT    = 16;
  localparam int SR_GLOBAL_OVERRUN_FLAG_BIT   = 17;
  localparam int SR_SLEEP_BIT   = 18;
  localparam int LAST_CH_LSB    = 12;

  // reset values
  localparam logic [7:0]        RST_CH_EN = 8'h00;
  localparam logic              RST_SLEEP = 1'h0;
  localparam logic [DATA_W-1:0] RST_DATA  = 10'h000;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_DONE = 1'b1
  } adcf_bus_state_type;

endpackage : adcf_pkg

// ---- design/adcf_flag.sv ----
/*
  adcf_flag: one sticky status flag, set by hardware, cleared by an access.
  assumes set and clear are single-cycle strobes on the same clock.
*/
`timescale 1ns/1ps
module adcf_flag (
  input  wire logic i_clock,
  input  wire logic i_rstn,
  input  wire logic i_set,
  input  wire logic i_clear,
  output logic      o_flag
);

  logic flag_q;

  // a fresh event beats a coincident clear, so nothing is lost
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      flag_q <= 1'b0;
    end else if (i_set) begin
      flag_q <= 1'b1;
    end else if (i_clear) begin
      flag_q <= 1'b0;
    end
  end

  assign o_flag = flag_q;

endmodule : adcf_flag

// ---- dv/adcf_core_model.sv ----
/*
  adcf_core_model: conversion core stand-in giving end-of-conversion strobes.
  assumes the bench asks for strobes on i_fire; a start request ends DELAY cycles later.
*/
`timescale 1ns/1ps
module adcf_core_model #(
  parameter int DELAY   = 5,
  parameter int AUTO_CH = 6
) (
  input  wire logic                        i_clock,
  input  wire logic                        i_start,
  input  wire logic                        i_fire,
  input  wire logic [adcf_pkg::CH_W-1:0]   i_fire_ch,
  input  wire logic [adcf_pkg::DATA_W-1:0] i_fire_data,
  output logic                             o_eoc_pulse,
  output logic      [adcf_pkg::CH_W-1:0]   o_eoc_channel,
  output logic      [adcf_pkg::DATA_W-1:0] o_eoc_data
);
  int                          cnt_q = 0;
  logic [adcf_pkg::DATA_W-1:0] junk_q = 10'h2aa;
  logic                        auto_end;
  // channel and data toggle outside the strobe, never hold a stale value
  always @(posedge i_clock) begin
    junk_q <= ~junk_q;
    if (i_start) begin
      cnt_q <= DELAY;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end
  end
  assign auto_end      = (cnt_q == 1);
  assign o_eoc_pulse   = i_fire | auto_end;
  assign o_eoc_channel = i_fire ? i_fire_ch : (auto_end ? 3'(AUTO_CH) : junk_q[2:0]);
  assign o_eoc_data    = i_fire ? i_fire_data : junk_q;
endmodule : adcf_core_model

// ---- dv/adcf_status_tb.sv ----
/*
  adcf_status_tb: self-checking bench for the status-flag block.
  assumes the core model on the strobe side and a 125 MHz clock.
*/
`timescale 1ns/1ps
module adcf_status_tb;
  localparam logic [7:0] STA = adcf_pkg::ADDR_STATUS;
  localparam logic [7:0] LST = adcf_pkg::ADDR_LAST;
  localparam logic [7:0] DIS = adcf_pkg::ADDR_CH_DIS;
  logic        clock = 1'h0, rstn = 1'h0, rd = 1'h0, wr = 1'h0, fire = 1'h0;
  logic        waitreq, start, sleep, pulse;
  logic [7:0]  addr = 8'h00;
  logic [3:0]  be = 4'hf;
  logic [2:0]  fch = 3'h0, ech;
  logic [9:0]  fdat = 10'h000, edat;
  logic [31:0] wdata = 32'h0000_0000, rdata, got;
  int          n_mismatch = 0, tests_run = 0;

  always #4 clock = ~clock;

  adcf_status dut (.i_clock(clock), .i_rstn(rstn), .i_address(addr), .i_read(rd), .i_write(wr),
    .i_writedata(wdata), .i_byteenable(be), .o_readdata(rdata), .o_waitrequest(waitreq),
    .i_eoc_pulse(pulse), .i_eoc_channel(ech), .i_eoc_data(edat), .o_start(start), .o_sleep(sleep));

  adcf_core_model core (.i_clock(clock), .i_start(start), .i_fire(fire), .i_fire_ch(fch),
    .i_fire_data(fdat), .o_eoc_pulse(pulse), .o_eoc_channel(ech), .o_eoc_data(edat));

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // strobe lands on the taken edge of a read, the completing edge of a write
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic f = 1'h0, input logic [2:0] c = 3'h0, input logic [9:0] v = 10'h000);
    int n;
    n = 0;
    @(posedge clock);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    fire <= f && !w;
    fch <= c;
    fdat <= v;
    // waitrequest read at the edge, before the slave updates it
    do begin
      @(posedge clock);
      n++;
      if (n == 1) fire <= f && w;
    end while (waitreq !== 1'h0 && n < 50);
    if (waitreq !== 1'h0) begin
      n_mismatch++;
      final_report();
    end
    got = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
    fire <= 1'h0;
  endtask : bus

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0000_0000);
    chk(nm, e, got);
  endtask : rchk

  task automatic conv(input logic [2:0] c, input logic [9:0] v);
    @(posedge clock);
    fire <= 1'h1;
    fch <= c;
    fdat <= v;
    @(posedge clock);
    fire <= 1'h0;
  endtask : conv

  function automatic logic [7:0] ca(input int k);
    ca = adcf_pkg::ADDR_CDR_BASE + 8'(4 * k);
  endfunction : ca

  function automatic logic [31:0] st(input logic [7:0] e, input logic [7:0] o, input logic d, input logic g);
    st = (32'(e) << adcf_pkg::SR_EOC_LSB) | (32'(o) << adcf_pkg::SR_CHANNEL_OVERRUN_FLAG_LSB)
       | (32'(d) << adcf_pkg::SR_DATA_READY_FLAG_BIT) | (32'(g) << adcf_pkg::SR_GLOBAL_OVERRUN_FLAG_BIT);
  endfunction : st

  task automatic s_store;
    rchk("reset status", STA, 32'h0000_0000);
    bus(1'h1, adcf_pkg::ADDR_CH_EN, 32'h0000_003f);
    conv(3'h1, 10'h155);
    rchk("cdr1", ca(1), 32'h0000_0155);
    rchk("status", STA, st(8'h00, 8'h00, 1'h1, 1'h0));
    rchk("last", LST, 32'h0000_1155);
    rchk("status", STA, st(8'h00, 8'h00, 1'h0, 1'h0));
    conv(3'h2, 10'h0aa);
    rchk("last", LST, 32'h0000_20aa);
    rchk("status", STA, 32'h0000_0000);
    rchk("unmapped", 8'h08, 32'h0000_0000);
  endtask : s_store

  task automatic s_overrun;
    conv(3'h2, 10'h001);
    conv(3'h2, 10'h002);
    rchk("status", STA, st(8'h04, 8'h04, 1'h1, 1'h1));
    rchk("cdr2", ca(2), 32'h0000_0002);
    rchk("status", STA, st(8'h00, 8'h00, 1'h1, 1'h0));
    conv(3'h2, 10'h003);
    conv(3'h2, 10'h004);
    rchk("cdr2", ca(2), 32'h0000_0004);
    bus(1'h0, STA, 32'h0000_0000, 1'h1, 3'h2, 10'h005);
    rchk("last", LST, 32'h0000_2005);
    bus(1'h0, STA, 32'h0000_0000, 1'h1, 3'h3, 10'h006);
    chk("status", st(8'h00, 8'h00, 1'h0, 1'h1), got);
    rchk("status", STA, st(8'h08, 8'h00, 1'h1, 1'h0));
    rchk("last", LST, 32'h0000_3006);
  endtask : s_overrun

  task automatic s_disabled;
    conv(3'h0, 10'h011);
    bus(1'h0, LST, 32'h0000_0000, 1'h1, 3'h7, 10'h3ff);
    chk("last", 32'h0000_0011, got);
    rchk("status", STA, 32'h0000_0000);
    bus(1'h1, DIS, 32'h0000_0010);
    bus(1'h0, ca(0), 32'h0000_0000, 1'h1, 3'h4, 10'h123);
    rchk("status", STA, 32'h0000_0000);
    rchk("cdr4", ca(4), 32'h0000_0000);
  endtask : s_disabled

  task automatic s_cross;
    conv(3'h2, 10'h021);
    conv(3'h1, 10'h022);
    rchk("status", STA, st(8'h06, 8'h00, 1'h1, 1'h1));
    bus(1'h0, ca(3), 32'h0000_0000, 1'h1, 3'h2, 10'h023);
    rchk("status", STA, st(8'h06, 8'h04, 1'h1, 1'h1));
    rchk("last", LST, 32'h0000_2023);
    rchk("cdr1", ca(1), 32'h0000_0022);
    conv(3'h0, 10'h0f0);
    conv(3'h1, 10'h0f1);
    rchk("last", LST, 32'h0000_10f1);
    rchk("status", STA, st(8'h01, 8'h00, 1'h0, 1'h1));
    bus(1'h0, ca(5), 32'h0000_0000, 1'h1, 3'h0, 10'h024);
    rchk("status", STA, st(8'h01, 8'h01, 1'h1, 1'h0));
  endtask : s_cross

  task automatic s_disable;
    bus(1'h1, DIS, 32'h0000_0020, 1'h1, 3'h0, 10'h031);
    rchk("status", STA, st(8'h01, 8'h01, 1'h1, 1'h1));
    rchk("last", LST, 32'h0000_0031);
    bus(1'h1, DIS, 32'h0000_0008, 1'h1, 3'h1, 10'h032);
    rchk("status", STA, st(8'h02, 8'h00, 1'h1, 1'h0));
    rchk("cdr1", ca(1), 32'h0000_0032);
    be <= 4'h0;
    bus(1'h1, adcf_pkg::ADDR_CH_EN, 32'h0000_00ff);
    be <= 4'hf;
    rchk("enabled", adcf_pkg::ADDR_CH_STAT, 32'h0000_0007);
  endtask : s_disable

  task automatic s_sleep;
    int n;
    n = 0;
    bus(1'h1, adcf_pkg::ADDR_MODE, 32'h0000_0001);
    repeat (8) @(posedge clock);
    chk("idle sleep", 32'h0000_0000, 32'(sleep));
    bus(1'h1, adcf_pkg::ADDR_CTRL, 32'h0000_0001);
    @(negedge clock);
    chk("start", 32'h0000_0001, 32'(start));
    while (sleep !== 1'h1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    chk("sleep", 32'h0000_0001, 32'(sleep));
    rchk("status", STA, st(8'h00, 8'h00, 1'h1, 1'h0) | (32'h0000_0001 << adcf_pkg::SR_SLEEP_BIT));
    bus(1'h1, adcf_pkg::ADDR_MODE, 32'h0000_0000);
    repeat (2) @(negedge clock);
    chk("woken", 32'h0000_0000, 32'(sleep));
  endtask : s_sleep

  initial begin
    repeat (16) @(posedge clock);
    rstn <= 1'h1;
    s_store();
    s_overrun();
    s_disabled();
    s_cross();
    s_disable();
    s_sleep();
    final_report();
  end

  // run needs well under 2000 cycles
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
endmodule : adcf_status_tb
